/* File: rtl/ea_exec_pkg.sv */
// constants, types and field layout for the instruction decode and execute core
// ----------------------------------------------------------------------------
// Overview of operation
// - Each instruction word is sorted into memory, jump, arithmetic or special group first.
// - Offset byte at or above 200B is extended by adding 177400B, except with base 0.
// - Base 0 page zero, 1 plus PC, 2 plus accumulator two, 3 three.
// - Deref set reads memory once at the address; that word is final.
// - Effective address is fixed before any register update of the instruction.
// - Two-bit target field picks accumulator zero through three directly.
// - Memory op 1 loads the accumulator, op 2 stores it at the address.
// - Jump op 0 loads the program counter with the effective address.
// - Jump op 1 saves PC plus one in accumulator three, then jumps.
// - Jump op 2 increments the memory word, writes it, skips when zero.
// - Jump op 3 decrements the memory word, writes it, skips when zero.
// - Increment and decrement skip never touch the carry flag.
// ----------------------------------------------------------------------------
`default_nettype none

package ea_exec_pkg;
	localparam int          WORD_W        = 16;
	// instruction bit k of the printed layout is word bit 15-k
	localparam int          ARITH_BIT     = 15;
	localparam int          OP_HI         = 14;
	localparam int          OP_LO         = 13;
	localparam int          ACC_HI        = 12;
	localparam int          ACC_LO        = 11;
	localparam int          DEREF_BIT     = 10;
	localparam int          BASE_HI       = 9;
	localparam int          BASE_LO       = 8;
	localparam int          OFFSET_HI     = 7;
	localparam logic [1:0]  LEAD_JUMP     = 2'h0;
	localparam logic [1:0]  LEAD_SPECIAL  = 2'h3;
	localparam logic [15:0] SIGN_THRESH   = 16'h0080;  // 200B
	localparam logic [15:0] SIGN_FILL     = 16'hff00;  // 177400B
	localparam logic [1:0]  BASE_PAGE0    = 2'h0;
	localparam logic [1:0]  BASE_PC       = 2'h1;
	localparam logic [1:0]  BASE_ACC2     = 2'h2;
	localparam logic [1:0]  MOP_LOAD      = 2'h1;
	localparam logic [1:0]  MOP_STORE     = 2'h2;
	localparam logic [1:0]  JOP_BRANCH    = 2'h0;
	localparam logic [1:0]  JOP_CALL      = 2'h1;
	localparam logic [1:0]  JOP_INC_SKIP  = 2'h2;
	localparam logic [1:0]  JOP_DEC_SKIP  = 2'h3;
	localparam logic [15:0] PC_RESET      = 16'h0000;
	localparam logic [15:0] ACC_RESET     = 16'h0000;
	localparam logic        CARRY_RESET   = 1'b0;

	typedef enum logic [1:0] {
		GRP_MEMORY  = 2'h0,
		GRP_JUMP    = 2'h1,
		GRP_ARITH   = 2'h2,
		GRP_SPECIAL = 2'h3
	} group_t;

	typedef enum logic [6:0] {
		ST_FETCH   = 7'h01,
		ST_FETCH_W = 7'h02,
		ST_ADDR    = 7'h04,
		ST_IND_W   = 7'h08,
		ST_EXEC    = 7'h10,
		ST_DATA_W  = 7'h20,
		ST_WRITE_W = 7'h40
	} state_t;
endpackage

`default_nettype wire

/* File: rtl/instr_exec_core.sv */
// instruction decode, effective address and memory/jump group execution
`default_nettype none

module instr_exec_core (
	// clock and reset
	input  wire logic                       i_sys_clk,
	input  wire logic                       i_arst_n,
	// main memory port
	output logic                            o_mem_req,
	output logic                            o_mem_we,
	output logic [ea_exec_pkg::WORD_W-1:0]  o_mem_addr,
	output logic [ea_exec_pkg::WORD_W-1:0]  o_mem_wdata,
	input  wire logic [ea_exec_pkg::WORD_W-1:0] i_mem_rdata,
	input  wire logic                       i_mem_ack,
	// architectural state
	output logic [ea_exec_pkg::WORD_W-1:0]  o_pc,
	output logic [ea_exec_pkg::WORD_W-1:0]  o_acc0,
	output logic [ea_exec_pkg::WORD_W-1:0]  o_acc1,
	output logic [ea_exec_pkg::WORD_W-1:0]  o_acc2,
	output logic [ea_exec_pkg::WORD_W-1:0]  o_acc3,
	output logic                            o_carry,
	output ea_exec_pkg::group_t             o_group
);
	import ea_exec_pkg::*;

	// ------------------------------------------------------------------------
	// state
	// ------------------------------------------------------------------------
	state_t              state_reg;
	logic [WORD_W-1:0]   pc_reg;
	logic [WORD_W-1:0]   ir_reg;
	logic [WORD_W-1:0]   ea_reg;
	logic [WORD_W-1:0]   acc_reg [4];
	logic                carry_reg;
	logic                zero_reg;
	group_t              group_reg;
	logic                req_reg;
	logic                we_reg;
	logic [WORD_W-1:0]   addr_reg;
	logic [WORD_W-1:0]   wdata_reg;

	// ------------------------------------------------------------------------
	// decode
	// ------------------------------------------------------------------------
	wire logic [1:0]        op_field                 = ir_reg[OP_HI:OP_LO];
	wire logic [1:0]        target_accumulator_field = ir_reg[ACC_HI:ACC_LO];
	wire logic [1:0]        jump_op_field            = ir_reg[ACC_HI:ACC_LO];
	wire logic [1:0]        memory_op_field          = op_field;
	wire logic              deref_flag               = ir_reg[DEREF_BIT];
	wire logic [1:0]        base_sel                 = ir_reg[BASE_HI:BASE_LO];
	wire logic [WORD_W-1:0] offset_byte_field        = {8'h00, ir_reg[OFFSET_HI:0]};
	wire logic [WORD_W-1:0] accumulator_two          = acc_reg[2];
	wire logic [WORD_W-1:0] accumulator_three        = acc_reg[3];

	wire group_t group_w = ir_reg[ARITH_BIT]       ? GRP_ARITH   :
	                       (op_field == LEAD_JUMP)    ? GRP_JUMP    :
	                       (op_field == LEAD_SPECIAL) ? GRP_SPECIAL : GRP_MEMORY;

	wire logic [WORD_W-1:0] sext_w = (offset_byte_field >= SIGN_THRESH) ?
	                                 offset_byte_field + SIGN_FILL : offset_byte_field;

	wire logic [WORD_W-1:0] ea_calc_w =
		(base_sel == BASE_PAGE0) ? offset_byte_field :
		(base_sel == BASE_PC)    ? sext_w + pc_reg :
		(base_sel == BASE_ACC2)  ? sext_w + accumulator_two :
		                           sext_w + accumulator_three;

	wire logic addr_user_w  = (group_w == GRP_MEMORY) || (group_w == GRP_JUMP);
	wire logic [WORD_W-1:0] modified_w = (jump_op_field == JOP_INC_SKIP) ?
	                                     i_mem_rdata + 16'h0001 : i_mem_rdata - 16'h0001;
	wire logic [WORD_W-1:0] pc_plus1_w = pc_reg + 16'h0001;
	wire logic [WORD_W-1:0] pc_plus2_w = pc_reg + 16'h0002;
	wire logic [WORD_W-1:0] target_acc_w = acc_reg[target_accumulator_field];

	// ------------------------------------------------------------------------
	// sequencer
	// ------------------------------------------------------------------------
	// memory handshake: request held until acknowledged; one request at a time
	always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			state_reg <= ST_FETCH;
			pc_reg    <= PC_RESET;
			ir_reg    <= 16'h0000;
			ea_reg    <= 16'h0000;
			zero_reg  <= 1'b0;
			group_reg <= GRP_MEMORY;
			req_reg   <= 1'b0;
			we_reg    <= 1'b0;
			addr_reg  <= 16'h0000;
			wdata_reg <= 16'h0000;
			for (int i = 0; i < 4; i++) begin
				acc_reg[i] <= ACC_RESET;
			end
		end else begin
			unique case (state_reg)
				ST_FETCH: begin
					req_reg   <= 1'b1;
					we_reg    <= 1'b0;
					addr_reg  <= pc_reg;
					state_reg <= ST_FETCH_W;
				end
				ST_FETCH_W: begin
					if (i_mem_ack) begin
						req_reg   <= 1'b0;
						ir_reg    <= i_mem_rdata;
						state_reg <= ST_ADDR;
					end
				end
				ST_ADDR: begin
					// address settles here, ahead of any register change
					group_reg <= group_w;
					ea_reg    <= ea_calc_w;
					if (addr_user_w && deref_flag) begin
						req_reg   <= 1'b1;
						addr_reg  <= ea_calc_w;
						state_reg <= ST_IND_W;
					end else begin
						state_reg <= ST_EXEC;
					end
				end
				ST_IND_W: begin
					if (i_mem_ack) begin
						// single level only: the pointer is never followed again
						req_reg   <= 1'b0;
						ea_reg    <= i_mem_rdata;
						state_reg <= ST_EXEC;
					end
				end
				ST_EXEC: begin
					if (group_reg == GRP_MEMORY && memory_op_field == MOP_LOAD) begin
						req_reg   <= 1'b1;
						addr_reg  <= ea_reg;
						state_reg <= ST_DATA_W;
					end else if (group_reg == GRP_MEMORY && memory_op_field == MOP_STORE) begin
						req_reg   <= 1'b1;
						we_reg    <= 1'b1;
						addr_reg  <= ea_reg;
						wdata_reg <= target_acc_w;
						state_reg <= ST_WRITE_W;
					end else if (group_reg == GRP_JUMP && jump_op_field == JOP_BRANCH) begin
						pc_reg    <= ea_reg;
						state_reg <= ST_FETCH;
					end else if (group_reg == GRP_JUMP && jump_op_field == JOP_CALL) begin
						acc_reg[3] <= pc_plus1_w;
						pc_reg     <= ea_reg;
						state_reg  <= ST_FETCH;
					end else if (group_reg == GRP_JUMP) begin
						req_reg   <= 1'b1;
						addr_reg  <= ea_reg;
						state_reg <= ST_DATA_W;
					end else begin
						// arithmetic and special groups are not executed here
						pc_reg    <= pc_plus1_w;
						state_reg <= ST_FETCH;
					end
				end
				ST_DATA_W: begin
					if (i_mem_ack) begin
						if (group_reg == GRP_MEMORY) begin
							req_reg                           <= 1'b0;
							acc_reg[target_accumulator_field] <= i_mem_rdata;
							pc_reg                            <= pc_plus1_w;
							state_reg                         <= ST_FETCH;
						end else begin
							// request stays up and turns into the write-back
							we_reg    <= 1'b1;
							wdata_reg <= modified_w;
							zero_reg  <= (modified_w == 16'h0000);
							state_reg <= ST_WRITE_W;
						end
					end
				end
				ST_WRITE_W: begin
					if (i_mem_ack) begin
						req_reg   <= 1'b0;
						we_reg    <= 1'b0;
						pc_reg    <= (group_reg == GRP_JUMP && zero_reg) ? pc_plus2_w : pc_plus1_w;
						state_reg <= ST_FETCH;
					end
				end
			endcase
		end
	end

	// carry is owned by the arithmetic group; nothing here writes it
	always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			carry_reg <= CARRY_RESET;
		end else begin
			carry_reg <= carry_reg;
		end
	end

	assign o_mem_req   = req_reg;
	assign o_mem_we    = we_reg;
	assign o_mem_addr  = addr_reg;
	assign o_mem_wdata = wdata_reg;
	assign o_pc        = pc_reg;
	assign o_acc0      = acc_reg[0];
	assign o_acc1      = acc_reg[1];
	assign o_acc2      = acc_reg[2];
	assign o_acc3      = acc_reg[3];
	assign o_carry     = carry_reg;
	assign o_group     = group_reg;

	// ------------------------------------------------------------------------
	// checks
	// ------------------------------------------------------------------------
	a_group_decode: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
		state_reg == ST_ADDR |=> o_group == (ir_reg[15] ? GRP_ARITH : ir_reg[14:13] == 2'h0 ? GRP_JUMP :
		                         ir_reg[14:13] == 2'h3 ? GRP_SPECIAL : GRP_MEMORY))
		else $error("group decode wrong");
	a_sign_extend: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
		sext_w == {{8{ir_reg[7]}}, ir_reg[7:0]})
		else $error("offset extension wrong");
	a_base_select: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
		state_reg == ST_ADDR && !ir_reg[10] && ir_reg[9:8] == 2'h1 |=>
		ea_reg == $past(pc_reg) + {{8{$past(ir_reg[7])}}, $past(ir_reg[7:0])})
		else $error("pc relative address wrong");
	a_page_zero: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
		state_reg == ST_ADDR && ir_reg[9:8] == 2'h0 |=> ea_reg == {8'h00, $past(ir_reg[7:0])})
		else $error("page zero address wrong");
	a_single_indirect: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
		state_reg == ST_IND_W && i_mem_ack |=> state_reg == ST_EXEC && ea_reg == $past(i_mem_rdata))
		else $error("indirection not single level");
	a_call_order: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
		state_reg == ST_EXEC && group_reg == GRP_JUMP && ir_reg[12:11] == 2'h1 |=>
		o_pc == $past(ea_reg) && o_acc3 == $past(pc_reg) + 16'h0001)
		else $error("call saved or jumped wrong");
	a_load_target: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
		state_reg == ST_DATA_W && i_mem_ack && group_reg == GRP_MEMORY && ir_reg[12:11] == 2'h1 |=>
		o_acc1 == $past(i_mem_rdata))
		else $error("load went to wrong accumulator");
	a_store_data: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
		state_reg == ST_EXEC && group_reg == GRP_MEMORY && ir_reg[14:13] == 2'h2 |=>
		o_mem_req && o_mem_we && o_mem_addr == $past(ea_reg) && o_mem_wdata == $past(target_acc_w))
		else $error("store request wrong");
	a_branch_pc: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
		state_reg == ST_EXEC && group_reg == GRP_JUMP && ir_reg[12:11] == 2'h0 |=>
		o_pc == $past(ea_reg) ##1 o_mem_req && o_mem_addr == $past(o_pc))
		else $error("branch did not redirect fetch");
	a_skip_zero: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
		state_reg == ST_WRITE_W && i_mem_ack && group_reg == GRP_JUMP |=>
		o_pc == $past(pc_reg) + ($past(zero_reg) ? 16'h0002 : 16'h0001))
		else $error("skip advance wrong");
	a_modify_value: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
		state_reg == ST_DATA_W && i_mem_ack && group_reg == GRP_JUMP |=>
		o_mem_we && o_mem_wdata == $past(i_mem_rdata) + (ir_reg[12:11] == 2'h2 ? 16'h0001 : 16'hffff))
		else $error("write back value wrong");
	a_carry_hold: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
		##1 $stable(o_carry))
		else $error("carry changed");
endmodule // instr_exec_core

`default_nettype wire

/* File: tb/mem_model.sv */
// behavioural main memory answering the core's word requests
`default_nettype none

module mem_model (
	// clock and reset
	input  wire logic        i_sys_clk,
	input  wire logic        i_arst_n,
	// request side
	input  wire logic        i_mem_req,
	input  wire logic        i_mem_we,
	input  wire logic [15:0] i_mem_addr,
	input  wire logic [15:0] i_mem_wdata,
	input  wire logic [3:0]  i_delay,
	// answer side
	output logic [15:0]      o_mem_rdata,
	output logic             o_mem_ack
);
	timeunit 1ns;
	timeprecision 1ps;
	// only 256 words: higher addresses alias, so tests stay below 100h
	logic [15:0] mem [0:255];
	logic [3:0]  wait_reg;

	always @(posedge i_sys_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			o_mem_ack   <= 1'b0;
			wait_reg    <= 4'h0;
			o_mem_rdata <= 16'h0000;
		end else if (o_mem_ack) begin
			o_mem_ack   <= 1'b0;
			wait_reg    <= 4'h0;
			// read data is gone after the ack cycle
			o_mem_rdata <= ~o_mem_rdata;
		end else if (i_mem_req && wait_reg == i_delay) begin
			o_mem_ack <= 1'b1;
			if (i_mem_we)
				mem[i_mem_addr[7:0]] <= i_mem_wdata;
			else
				o_mem_rdata <= mem[i_mem_addr[7:0]];
		end else if (i_mem_req) begin
			wait_reg <= wait_reg + 4'h1;
		end
	end
endmodule // mem_model

`default_nettype wire

/* File: tb/testbench.sv */
// self-checking bench: small programs run against the memory model
`default_nettype none

module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	import ea_exec_pkg::*;

	typedef struct {
		logic [15:0] prog [3];
		logic [15:0] ia [3];
		logic [15:0] iv [3];
		logic [15:0] pc;
		logic [1:0]  acn;
		logic [15:0] acv;
		logic [15:0] ma;
		logic [15:0] mv;
	} row_t;

	localparam logic [15:0] LOOP = 16'h0100;

	logic        i_sys_clk = 1'b0;
	logic        i_arst_n = 1'b0;
	logic [3:0]  delay = 4'h0;
	logic        o_mem_req, o_mem_we, o_mem_ack, o_carry;
	logic [15:0] o_mem_addr, o_mem_wdata, o_mem_rdata, o_pc, o_acc0, o_acc1, o_acc2, o_acc3;
	group_t      o_group;
	logic [15:0] acs [4];
	logic [3:0]  seen = 4'h0;
	row_t        rows [9];
	int          fail_count = 0;
	int          n_checks = 0;

	assign acs[0] = o_acc0;
	assign acs[1] = o_acc1;
	assign acs[2] = o_acc2;
	assign acs[3] = o_acc3;

	initial begin
		forever #4 i_sys_clk = ~i_sys_clk;
	end

	always @(posedge i_sys_clk) begin
		if (i_arst_n)
			seen[o_group] <= 1'b1;
	end

	instr_exec_core u_instr_exec_core (.i_sys_clk(i_sys_clk), .i_arst_n(i_arst_n), .o_mem_req(o_mem_req),
		.o_mem_we(o_mem_we), .o_mem_addr(o_mem_addr), .o_mem_wdata(o_mem_wdata), .i_mem_rdata(o_mem_rdata),
		.i_mem_ack(o_mem_ack), .o_pc(o_pc), .o_acc0(o_acc0), .o_acc1(o_acc1), .o_acc2(o_acc2), .o_acc3(o_acc3),
		.o_carry(o_carry), .o_group(o_group));
	mem_model u_mem_model (.i_sys_clk(i_sys_clk), .i_arst_n(i_arst_n), .i_mem_req(o_mem_req),
		.i_mem_we(o_mem_we), .i_mem_addr(o_mem_addr), .i_mem_wdata(o_mem_wdata), .i_delay(delay),
		.o_mem_rdata(o_mem_rdata), .o_mem_ack(o_mem_ack));

	function automatic logic [15:0] mi(input logic [1:0] op, ac, input logic i, input logic [1:0] b,
		input logic [7:0] d);
		return {1'b0, op, ac, i, b, d};
	endfunction

	function automatic logic [15:0] ji(input logic [1:0] jf, input logic i, input logic [1:0] b,
		input logic [7:0] d);
		return {3'b000, jf, i, b, d};
	endfunction

	task automatic check(input string nm, input logic [15:0] e, input logic [15:0] g);
		n_checks++;
		if (g !== e) begin
			$display("unexpected %s expected %h seen %h", nm, e, g);
			fail_count++;
		end
	endtask

	task automatic stop_test();
		$display("checks %0d mismatches %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	task automatic run_row(input int r, input logic [3:0] dly);
		@(posedge i_sys_clk);
		i_arst_n <= 1'b0;
		delay    <= dly;
		repeat (10) @(posedge i_sys_clk);
		for (int a = 0; a < 256; a++)
			u_mem_model.mem[a] = 16'h0000;
		for (int k = 0; k < 3; k++)
			u_mem_model.mem[k] = rows[r].prog[k];
		for (int k = 0; k < 3; k++)
			u_mem_model.mem[rows[r].ia[k][7:0]] = rows[r].iv[k];
		check("pc in reset", 16'h0000, o_pc);
		check("group in reset", {14'h0000, GRP_MEMORY}, {14'h0000, o_group});
		check("req in reset", 16'h0000, {15'h0000, o_mem_req});
		i_arst_n <= 1'b1;
		@(posedge i_sys_clk);
		#1;
		check("first fetch", 16'h0001, {o_mem_addr[14:0], o_mem_req} | {15'h0000, o_mem_we} << 1);
		repeat (150) @(posedge i_sys_clk);
		#1;
		check("pc", rows[r].pc, o_pc);
		check("accumulator", rows[r].acv, acs[rows[r].acn]);
		check("memory word", rows[r].mv, u_mem_model.mem[rows[r].ma[7:0]]);
		check("carry", 16'h0000, {15'h0000, o_carry});
	endtask

	initial begin
		rows[0] = '{'{mi(1,1,0,0,8'h40), mi(2,1,0,1,8'h40), LOOP}, '{16'h40, 16'h7f, 16'h7f},
			'{16'h1234, 0, 0}, 16'h2, 2'h1, 16'h1234, 16'h41, 16'h1234};
		rows[1] = '{'{mi(1,2,0,0,8'h40), mi(1,0,0,2,8'hfe), LOOP}, '{16'h40, 16'h4e, 16'h7f},
			'{16'h50, 16'hbeef, 0}, 16'h2, 2'h0, 16'hbeef, 16'h40, 16'h50};
		rows[2] = '{'{mi(1,3,0,0,8'h40), mi(1,1,1,3,8'h02), LOOP}, '{16'h40, 16'h62, 16'h70},
			'{16'h60, 16'h70, 16'h5a5a}, 16'h2, 2'h1, 16'h5a5a, 16'h62, 16'h70};
		rows[3] = '{'{ji(2,0,0,8'h40), ji(0,0,0,8'h30), LOOP}, '{16'h40, 16'h7f, 16'h7f},
			'{16'hffff, 0, 0}, 16'h2, 2'h0, 16'h0, 16'h40, 16'h0};
		rows[4] = '{'{ji(3,0,0,8'h40), LOOP, ji(0,0,0,8'h30)}, '{16'h40, 16'h7f, 16'h7f},
			'{16'h2, 0, 0}, 16'h1, 2'h0, 16'h0, 16'h40, 16'h1};
		rows[5] = '{'{ji(3,0,0,8'h40), ji(0,0,0,8'h30), LOOP}, '{16'h40, 16'h7f, 16'h7f},
			'{16'h1, 0, 0}, 16'h2, 2'h0, 16'h0, 16'h40, 16'h0};
		rows[6] = '{'{mi(1,3,0,0,8'h40), ji(1,0,3,8'h01), 16'h0}, '{16'h40, 16'h45, 16'h7f},
			'{16'h44, LOOP, 0}, 16'h45, 2'h3, 16'h2, 16'h45, LOOP};
		rows[7] = '{'{16'h8000, 16'h6000, ji(0,1,0,8'h40)}, '{16'h40, 16'h50, 16'h7f},
			'{16'h50, LOOP, 0}, 16'h50, 2'h0, 16'h0, 16'h50, LOOP};
		rows[8] = '{'{mi(1,0,0,0,8'h40), ji(2,0,1,8'hff), LOOP}, '{16'h40, 16'h7f, 16'h7f},
			'{16'h7777, 0, 0}, 16'h2, 2'h0, 16'h7777, 16'h0, 16'h2041};
		// first pass with a prompt memory, second with a slow one
		for (int p = 0; p < 2; p++)
			for (int r = 0; r < 9; r++)
				run_row(r, p ? 4'h3 : 4'h0);
		check("groups seen", 16'h000f, {12'h000, seen});
		// awkward case: reset lands while a fetch request is outstanding
		@(posedge i_sys_clk);
		while (o_mem_req !== 1'b1)
			@(posedge i_sys_clk);
		i_arst_n <= 1'b0;
		#1;
		check("req after async reset", 16'h0000, {15'h0000, o_mem_req});
		check("pc after async reset", 16'h0000, o_pc);
		check("acc0 after async reset", 16'h0000, o_acc0);
		stop_test();
	end

	initial begin
		#(8 * 5000);
		fail_count++;
		stop_test();
	end
endmodule // testbench

`default_nettype wire
